// ===== rtl/watchdog_sleep_wake_control.sv
// Purpose: watchdog, sleep entry, wake-up and interrupt flag control
// Assumes: all inputs synchronous to sys_clk; Avalon-MM slave with waitrequest
// Notes:   watchdog counts sys_clk, which keeps running while the core sleeps
//
// Overview of operation
// - Port B pins 7..4 change sets flag bit 0; bit 3 enables it.
// - Change coinciding with a port B read may not set the flag.
// - External pin flag may set at any time in the cycle.
// - Taking an interrupt pushes only the return address; software saves context.
// - Watchdog runs from sys_clk, which keeps running, so it counts even during sleep.
// - Time-out when awake resets device; while asleep it wakes without reset.
// - Base time-out 18 ms; postscaler up to 1:128 extends it.
// - Clear-watchdog or sleep instruction clears counter and assigned postscaler.
// - Watchdog time-out clears the time-out status flag.
// - Configuration word bit 2 clear disables the watchdog permanently.
// - Sleep clears watchdog, clears power-down flag, sets time-out flag, stops oscillator.
// - Watchdog reset never drives the external master-reset pin low.
// - Wake on reset pin (reset), watchdog or enabled interrupt (continue).
// - Power-down flag set at power-up, cleared on sleep entry.
// - Sleep instruction prefetches the instruction at PC plus one.
// - Interrupt wakes only with its own enable set, regardless of global enable.
// - Wake with global enable set runs next instruction then vectors to 0004h.
// - Global enable clear with an enabled pending flag makes sleep a no-op.
// - Watchdog is cleared on every watchdog or interrupt wake-up, not on a reset-pin wake.
// - Flags set by events regardless of any enable bit.
`timescale 1ns/10ps
`include "wdt_sleep_defines.svh"

module watchdog_sleep_wake_control #(
    parameter int unsigned WDT_BASE_CYCLES = `WDT_BASE_CYCLES
) (
    input  wire logic                     sys_clk,
    input  wire logic                     srst,
    input  wire logic [15:0]              address,
    input  wire logic                     read,
    input  wire logic                     write,
    input  wire logic [31:0]              writedata,
    input  wire logic [3:0]               byteenable,
    output logic      [31:0]              readdata,
    output logic                          waitrequest,
    input  wire logic [7:0]               port_b_a_in,
    input  wire logic                     port_b_read,
    input  wire logic                     ext_irq_pin,
    input  wire logic                     timer0_overflow_evt,
    input  wire logic [7:0]               periph_evt,
    input  wire logic [7:0]               cfg_word_in,
    input  wire logic                     master_reset_pin_n,
    input  wire logic                     clear_watchdog_instr,
    input  wire logic                     sleep_instr,
    input  wire logic                     instr_boundary,
    input  wire wdt_sleep_pkg::prog_addr_t pc_in,
    input  wire wdt_sleep_pkg::prog_addr_t pc_next,
    output logic                          chip_reset,
    output logic                          sleeping,
    output logic                          osc_drive_en,
    output logic                          wake_pulse,
    output logic                          sleep_as_nop,
    output logic                          vector_req,
    output wdt_sleep_pkg::prog_addr_t     vector_addr,
    output wdt_sleep_pkg::prog_addr_t     push_addr,
    output wdt_sleep_pkg::prog_addr_t     fetch_addr
);
    import wdt_sleep_pkg::*;

    localparam prog_addr_t IRQ_VECTOR = 13'h0004;

    // ==========================================================
    // State
    logic [7:0]   int_control_r;
    logic [7:0]   periph_flags_r;
    logic [7:0]   periph_enables_r;
    logic [7:0]   option_r;
    logic [7:0]   cfg_r;
    logic         timeout_flag_r;
    logic         power_down_flag_r;
    power_state_t state_r;
    logic [31:0]  wdt_cnt_r;
    logic [6:0]   post_cnt_r;
    logic [3:0]   port_latch_r;
    logic         ext_pin_d_r;
    logic         wait_r;
    logic [7:0]   rdata_r;
    logic         chip_reset_r;
    logic         wake_r;
    logic         osc_drive_r;
    logic         nop_r;
    logic         vector_r;
    prog_addr_t   push_r;
    prog_addr_t   fetch_r;
    prog_addr_t   vec_addr_r;

    // ==========================================================
    // Register decode
    function automatic logic reg_hit(input logic [15:0] addr, input logic [13:0] idx);
        reg_hit = (addr[1:0] == 2'h0) && (addr[15:2] == idx);
    endfunction

    logic bus_wr;
    logic wr_ic;
    logic wr_pf;
    logic wr_pe;
    logic wr_opt;
    assign bus_wr = write && !wait_r && byteenable[0];
    assign wr_ic  = bus_wr && reg_hit(address, `IDX_INT_CONTROL);
    assign wr_pf  = bus_wr && reg_hit(address, `IDX_PERIPH_FLAGS);
    assign wr_pe  = bus_wr && reg_hit(address, `IDX_PERIPH_ENABLES);
    assign wr_opt = bus_wr && reg_hit(address, `IDX_OPTION_CONTROL);

    // ==========================================================
    // Event detection
    logic port_change;
    logic ext_edge;
    logic periph_req;
    logic pending;
    logic global_irq_enable;
    logic take_irq;
    assign global_irq_enable = int_control_r[`IC_GLOBAL_EN];
    // Pins compared against the value last read; a read in progress masks it
    assign port_change = (port_b_a_in[7:4] != port_latch_r) && !port_b_read;
    assign ext_edge = option_r[`OPT_EDGE_SEL] ? (ext_irq_pin && !ext_pin_d_r)
                                              : (!ext_irq_pin && ext_pin_d_r);
    assign periph_req = int_control_r[`IC_PERIPH_EN]
                        && |(periph_flags_r & periph_enables_r);
    assign pending = (int_control_r[`IC_T0_EN] && int_control_r[`IC_T0_FLAG])
                     || (int_control_r[`IC_EXT_EN] && int_control_r[`IC_EXT_FLAG])
                     || (int_control_r[`IC_PORT_EN] && int_control_r[`IC_PORT_FLAG])
                     || periph_req;
    // Guard on vector_r keeps a second request off until GLOBAL_IRQ_ENABLE drops
    assign take_irq = instr_boundary && global_irq_enable && pending
                      && (state_r == PS_RUN) && !vector_r;

    // ==========================================================
    // Watchdog timing
    logic       wdt_en;
    logic       base_tick;
    logic [6:0] post_target;
    logic       timeout;
    logic       sleep_enter;
    logic       wake;
    logic       wdt_clear;
    assign wdt_en = cfg_r[`CFG_WDT_ENABLE];
    assign base_tick = wdt_en && (wdt_cnt_r == WDT_BASE_CYCLES - 32'd1);
    // Ratio minus one; unassigned postscaler means every base period times out
    assign post_target = option_r[`OPT_PSC_ASSIGN]
                         ? 7'((8'h01 << option_r[2:0]) - 8'h01) : 7'h00;
    assign timeout = base_tick && (post_cnt_r == post_target);
    assign sleep_enter = (state_r == PS_RUN) && sleep_instr
                         && !(!global_irq_enable && pending);
    assign wake = (state_r == PS_SLEEP) && (timeout || pending);
    assign wdt_clear = clear_watchdog_instr || sleep_enter || wake;

    // ==========================================================
    // Bus slave: one wait cycle, then answer
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            wait_r <= 1'b1;
        end else if ((read || write) && wait_r) begin
            wait_r <= 1'b0;
        end else begin
            wait_r <= 1'b1;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            rdata_r <= 8'h00;
        end else if (read && wait_r) begin
            unique case (1'b1)
                reg_hit(address, `IDX_INT_CONTROL):    rdata_r <= int_control_r;
                reg_hit(address, `IDX_PERIPH_FLAGS):   rdata_r <= periph_flags_r;
                reg_hit(address, `IDX_PERIPH_ENABLES): rdata_r <= periph_enables_r;
                reg_hit(address, `IDX_OPTION_CONTROL): rdata_r <= option_r;
                reg_hit(address, `IDX_CONFIG_WORD):    rdata_r <= cfg_r;
                reg_hit(address, `IDX_POWER_STATUS): begin
                    rdata_r <= {3'h0, timeout_flag_r, power_down_flag_r, 2'h0, state_r};
                end
                default:                               rdata_r <= 8'h00;
            endcase
        end
    end

    // ==========================================================
    // Software registers
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            option_r         <= `OPTION_RST;
            periph_enables_r <= `PERIPH_RST;
        end else begin
            if (wr_opt) begin
                option_r <= writedata[7:0];
            end
            if (wr_pe) begin
                periph_enables_r <= writedata[7:0] & `PERIPH_MASK;
            end
        end
    end

    // Fuse caught at reset release; only a new reset can change it
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            cfg_r <= cfg_word_in;
        end
    end

    // ==========================================================
    // Interrupt control: hardware sets win over software clears
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            int_control_r <= `INT_CONTROL_RST;
        end else begin
            if (wr_ic) begin
                int_control_r <= writedata[7:0];
            end
            if (timer0_overflow_evt) begin
                int_control_r[`IC_T0_FLAG] <= 1'b1;
            end
            if (ext_edge) begin
                int_control_r[`IC_EXT_FLAG] <= 1'b1;
            end
            if (port_change) begin
                int_control_r[`IC_PORT_FLAG] <= 1'b1;
            end
            if (vector_r) begin
                int_control_r[`IC_GLOBAL_EN] <= 1'b0;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            periph_flags_r <= `PERIPH_RST;
        end else if (wr_pf) begin
            periph_flags_r <= (writedata[7:0] | periph_evt) & `PERIPH_MASK;
        end else begin
            periph_flags_r <= (periph_flags_r | periph_evt) & `PERIPH_MASK;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            port_latch_r <= 4'h0;
            ext_pin_d_r  <= ext_irq_pin; // No false edge after reset
        end else begin
            ext_pin_d_r <= ext_irq_pin;
            if (port_b_read) begin
                port_latch_r <= port_b_a_in[7:4];
            end
        end
    end

    // ==========================================================
    // Watchdog counter and postscaler
    always_ff @(posedge sys_clk) begin
        if (srst || !wdt_en || wdt_clear || base_tick) begin
            wdt_cnt_r <= 32'h0;
        end else begin
            // Counts in sleep too: its clock is not the stopped core clock
            wdt_cnt_r <= wdt_cnt_r + 32'h1;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst || wdt_clear || timeout || !option_r[`OPT_PSC_ASSIGN]) begin
            post_cnt_r <= 7'h0;
        end else if (base_tick) begin
            post_cnt_r <= post_cnt_r + 7'h1;
        end
    end

    // ==========================================================
    // Power state register
    always_ff @(posedge sys_clk) begin
        if (srst || !master_reset_pin_n) begin
            state_r <= PS_RUN;
        end else if (sleep_enter) begin
            state_r <= PS_SLEEP;
        end else if (wake) begin
            state_r <= PS_RUN;
        end
    end

    // ==========================================================
    // Oscillator driver and status flags
    always_ff @(posedge sys_clk) begin
        if (srst || !master_reset_pin_n) begin
            osc_drive_r <= 1'b1;
        end else if (sleep_enter) begin
            osc_drive_r <= 1'b0;
        end else if (wake) begin
            osc_drive_r <= 1'b1;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            timeout_flag_r    <= 1'b1;
            power_down_flag_r <= 1'b1;
        end else begin
            if (timeout) begin
                timeout_flag_r <= 1'b0;
            end else if (sleep_enter) begin
                timeout_flag_r <= 1'b1;
            end
            if (sleep_enter) begin
                power_down_flag_r <= 1'b0;
            end
        end
    end

    // ==========================================================
    // Reset, wake and vectoring outputs
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            chip_reset_r <= 1'b0;
            wake_r       <= 1'b0;
            nop_r        <= 1'b0;
        end else begin
            // Internal reset only; the master-reset pin is an input here
            chip_reset_r <= ((state_r == PS_RUN) && timeout) || !master_reset_pin_n;
            wake_r       <= wake;
            nop_r        <= (state_r == PS_RUN) && sleep_instr && !global_irq_enable && pending;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            vector_r <= 1'b0;
            push_r   <= 13'h0000;
        end else begin
            // Boundary after wake closes the prefetched instruction, so vectoring follows it
            vector_r <= take_irq;
            if (take_irq) begin
                push_r <= pc_next;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            fetch_r <= 13'h0000;
        end else if (sleep_instr && (state_r == PS_RUN)) begin
            fetch_r <= pc_in + 13'h0001;
        end
    end

    // ==========================================================
    // Fixed interrupt vector
    // Held in a flop so every output leaves from a register
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            vec_addr_r <= IRQ_VECTOR;
        end
    end

    // ==========================================================
    // Output drive
    assign readdata     = {24'h000000, rdata_r};
    assign waitrequest  = wait_r;
    assign chip_reset   = chip_reset_r;
    assign sleeping     = state_r == PS_SLEEP ? 1'b1 : 1'b0;
    assign osc_drive_en = osc_drive_r;
    assign wake_pulse   = wake_r;
    assign sleep_as_nop = nop_r;
    assign vector_req   = vector_r;
    assign vector_addr  = vec_addr_r;
    assign push_addr    = push_r;
    assign fetch_addr   = fetch_r;

endmodule

// ===== rtl/wdt_sleep_defines.svh
// Purpose: constants for the watchdog, sleep and wake-up control block
// Assumes: 200 MHz system clock, 32-bit register bus
// Notes:   register byte address is four times the register index
`ifndef WDT_SLEEP_DEFINES_SVH
`define WDT_SLEEP_DEFINES_SVH

// ==========================================================
// Register indices
`define IDX_POWER_STATUS   14'h0003
`define IDX_INT_CONTROL    14'h000B
`define IDX_PERIPH_FLAGS   14'h000C
`define IDX_OPTION_CONTROL 14'h0081
`define IDX_PERIPH_ENABLES 14'h008C
`define IDX_CONFIG_WORD    14'h2007

// ==========================================================
// Interrupt control fields
`define IC_GLOBAL_EN   7
`define IC_PERIPH_EN   6
`define IC_T0_EN       5
`define IC_EXT_EN      4
`define IC_PORT_EN     3
`define IC_T0_FLAG     2
`define IC_EXT_FLAG    1
`define IC_PORT_FLAG   0

// ==========================================================
// Option, configuration and status fields
`define OPT_EDGE_SEL   6
`define OPT_PSC_ASSIGN 3
`define CFG_WDT_ENABLE 2
`define ST_TIMEOUT     4
`define ST_POWER_DOWN  3

// ==========================================================
// Reset values and peripheral flag mask
`define INT_CONTROL_RST 8'h00
`define PERIPH_RST      8'h00
`define OPTION_RST      8'hFF
`define PERIPH_MASK     8'hF7

// ==========================================================
// Timing
`define SYS_CLK_MHZ     200
`define WDT_PERIOD_US   18000
`define WDT_BASE_CYCLES (`WDT_PERIOD_US * `SYS_CLK_MHZ)

`endif

// ===== rtl/wdt_sleep_pkg.sv
// Purpose: shared types for the watchdog, sleep and wake-up control block
// Assumes: nothing beyond SystemVerilog
// Notes:   constants live in wdt_sleep_defines.svh
package wdt_sleep_pkg;

    typedef enum logic [0:0] {
        PS_RUN   = 1'b0,
        PS_SLEEP = 1'b1
    } power_state_t;

    typedef logic [12:0] prog_addr_t;

endpackage

// ===== sim/tb_watchdog_sleep_wake_control.sv
// Purpose: self-checking bench for watchdog_sleep_wake_control
// Assumes: watchdog base count shortened to 20 cycles
// Notes:   reads are queued by the driver and checked by a watcher
`timescale 1ns/10ps
`include "wdt_sleep_defines.svh"
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin fail_count++; \
    $display("[FAIL] t=%0t got %0h exp %0h", $time, g, e); end end
`define WAIT_UNTIL(c, lim) n = 0; while (!(c) && n < lim) begin @(posedge sys_clk); n++; end \
    if (!(c)) fail_count++;
module tb_watchdog_sleep_wake_control;
    import wdt_sleep_pkg::*;
    localparam int BASE = 20;
    logic        sys_clk, srst, read, write, port_b_read, ext_irq_pin, timer0_overflow_evt, waitrequest;
    logic        master_reset_pin_n, clear_watchdog_instr, sleep_instr, instr_boundary, chip_reset;
    logic        sleeping, osc_drive_en, wake_pulse, sleep_as_nop, vector_req;
    logic [15:0] address;
    logic [31:0] writedata, readdata;
    logic [3:0]  byteenable;
    logic [7:0]  port_b_a_in, periph_evt, cfg_word_in, cfgv, exp_v, exp_q[$];
    prog_addr_t  pc_in, pc_next, vector_addr, push_addr, fetch_addr, pc, last_push;
    int          fail_count, checks_done, cyc_n, n, rst_cnt, vec_cnt, r0, lo;

    watchdog_sleep_wake_control #(.WDT_BASE_CYCLES(BASE)) u_dut (
        .sys_clk(sys_clk), .srst(srst), .address(address), .read(read), .write(write),
        .writedata(writedata), .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest),
        .port_b_a_in(port_b_a_in), .port_b_read(port_b_read), .ext_irq_pin(ext_irq_pin),
        .timer0_overflow_evt(timer0_overflow_evt), .periph_evt(periph_evt), .cfg_word_in(cfg_word_in),
        .master_reset_pin_n(master_reset_pin_n), .clear_watchdog_instr(clear_watchdog_instr),
        .sleep_instr(sleep_instr), .instr_boundary(instr_boundary), .pc_in(pc_in), .pc_next(pc_next),
        .chip_reset(chip_reset), .sleeping(sleeping), .osc_drive_en(osc_drive_en), .wake_pulse(wake_pulse),
        .sleep_as_nop(sleep_as_nop), .vector_req(vector_req), .vector_addr(vector_addr),
        .push_addr(push_addr), .fetch_addr(fetch_addr));

    // ==========================================================
    // Clock, watcher and tasks
    initial begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end

    always @(posedge sys_clk) begin
        cyc_n++;
        if (chip_reset === 1'b1) rst_cnt++;
        if (vector_req === 1'b1) begin
            vec_cnt++;
            last_push = push_addr;
        end
        if (read && waitrequest === 1'b0) begin
            exp_v = exp_q.pop_front();
            `CHK(readdata, {24'h0, exp_v})
        end
        // Ceiling well above the roughly 700 cycles the tests need
        if (cyc_n == 20000) begin
            fail_count++;
            close_out();
        end
    end

    task automatic close_out();
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask

    // Idle edge after release so the next request never retoggles a strobe in one step
    task automatic bus(input logic [13:0] idx, input logic is_wr, input logic [7:0] d, input logic [3:0] be);
        address <= {idx, 2'b00};
        read <= !is_wr;
        write <= is_wr;
        writedata <= {24'h0, d};
        byteenable <= be;
        `WAIT_UNTIL(n > 0 && waitrequest === 1'b0, 50)
        read <= 1'b0;
        write <= 1'b0;
        @(posedge sys_clk);
    endtask

    task automatic wr(input logic [13:0] idx, input logic [7:0] d, input logic [3:0] be = 4'hF);
        bus(idx, 1'b1, d, be);
    endtask

    task automatic rd(input logic [13:0] idx, input logic [7:0] e);
        exp_q.push_back(e);
        bus(idx, 1'b0, 8'h00, 4'hF);
    endtask

    task automatic do_sleep();
        pc = prog_addr_t'($urandom);
        pc_in <= pc;
        sleep_instr <= 1'b1;
        @(posedge sys_clk);
        sleep_instr <= 1'b0;
        @(posedge sys_clk);
    endtask

    task automatic step_over();
        instr_boundary <= 1'b1;
        pc_next <= prog_addr_t'($urandom);
        @(posedge sys_clk);
        instr_boundary <= 1'b0;
        repeat (3) @(posedge sys_clk);
    endtask

    // ==========================================================
    // Main sequence
    initial begin
        {read, write, port_b_read, ext_irq_pin, timer0_overflow_evt, clear_watchdog_instr} = '0;
        {sleep_instr, instr_boundary, address, writedata, byteenable, port_b_a_in, periph_evt} = '0;
        {pc_in, pc_next} = '0;
        master_reset_pin_n = 1'b1;
        srst = 1'b1;
        r0 = $urandom(32'h54818636);
        cfgv = 8'($urandom) | 8'h04;
        cfg_word_in = cfgv;
        repeat (10) @(posedge sys_clk);
        srst <= 1'b0;
        rd(`IDX_OPTION_CONTROL, `OPTION_RST);
        rd(`IDX_INT_CONTROL, `INT_CONTROL_RST);
        rd(`IDX_PERIPH_FLAGS, 8'h00);
        rd(`IDX_POWER_STATUS, 8'h18);
        wr(`IDX_CONFIG_WORD, ~cfgv);
        rd(`IDX_CONFIG_WORD, cfgv);
        rd(14'h0100, 8'h00);
        r0 = $urandom;
        wr(`IDX_PERIPH_ENABLES, 8'(r0));
        wr(`IDX_PERIPH_ENABLES, ~8'(r0), 4'hE);
        rd(`IDX_PERIPH_ENABLES, 8'(r0) & `PERIPH_MASK);
        port_b_a_in <= 8'h0F;
        rd(`IDX_INT_CONTROL, 8'h00);
        port_b_a_in <= 8'h5F;
        ext_irq_pin <= 1'b1;
        timer0_overflow_evt <= 1'b1;
        periph_evt <= 8'hFF;
        @(posedge sys_clk);
        timer0_overflow_evt <= 1'b0;
        periph_evt <= 8'h00;
        port_b_read <= 1'b1;
        rd(`IDX_INT_CONTROL, 8'h07);
        port_b_read <= 1'b0;
        rd(`IDX_PERIPH_FLAGS, `PERIPH_MASK);
        wr(`IDX_INT_CONTROL, 8'h00);
        wr(`IDX_PERIPH_FLAGS, 8'h00);
        ext_irq_pin <= 1'b0;
        rd(`IDX_INT_CONTROL, 8'h00);
        // Postscaler ratios 1..8 and the unassigned case
        for (int p = 0; p < 5; p++) begin
            lo = BASE * ((p == 4) ? 1 : (1 << p));
            wr(`IDX_OPTION_CONTROL, (p == 4) ? 8'h47 : 8'h48 | 8'(p));
            clear_watchdog_instr <= 1'b1;
            @(posedge sys_clk);
            clear_watchdog_instr <= 1'b0;
            `WAIT_UNTIL(chip_reset === 1'b1, 2000)
            `CHK(n >= lo - 2 && n <= lo + 3, 1'b1)
        end
        rd(`IDX_POWER_STATUS, 8'h08);
        r0 = rst_cnt;
        repeat (8) begin
            clear_watchdog_instr <= 1'b1;
            @(posedge sys_clk);
            clear_watchdog_instr <= 1'b0;
            repeat (11) @(posedge sys_clk);
        end
        `CHK(rst_cnt == r0, 1'b1)
        do_sleep();
        `CHK(sleeping, 1'b1)
        `CHK(fetch_addr, prog_addr_t'(pc + 1))
        rd(`IDX_POWER_STATUS, 8'h11);
        `WAIT_UNTIL(sleeping === 1'b0, 200)
        `CHK(n <= BASE, 1'b1)
        rd(`IDX_POWER_STATUS, 8'h00);
        wr(`IDX_OPTION_CONTROL, 8'h4F);
        wr(`IDX_INT_CONTROL, 8'h10);
        wr(`IDX_PERIPH_ENABLES, 8'h01);
        do_sleep();
        timer0_overflow_evt <= 1'b1;
        periph_evt <= 8'h01;
        @(posedge sys_clk);
        timer0_overflow_evt <= 1'b0;
        periph_evt <= 8'h00;
        repeat (4) @(posedge sys_clk);
        `CHK(sleeping, 1'b1)
        ext_irq_pin <= 1'b1;
        `WAIT_UNTIL(sleeping === 1'b0, 10)
        `CHK(n < 5, 1'b1)
        r0 = vec_cnt;
        step_over();
        `CHK(vec_cnt == r0, 1'b1)
        do_sleep();
        `CHK(sleep_as_nop, 1'b1)
        `CHK(sleeping, 1'b0)
        ext_irq_pin <= 1'b0;
        wr(`IDX_INT_CONTROL, 8'h90);
        do_sleep();
        `CHK(sleeping, 1'b1)
        ext_irq_pin <= 1'b1;
        `WAIT_UNTIL(sleeping === 1'b0, 10)
        r0 = vec_cnt;
        step_over();
        `CHK(vec_cnt == r0 + 1, 1'b1)
        `CHK(last_push, pc_next)
        rd(`IDX_INT_CONTROL, 8'h12);
        master_reset_pin_n <= 1'b0;
        repeat (2) @(posedge sys_clk);
        `CHK(chip_reset, 1'b1)
        master_reset_pin_n <= 1'b1;
        cfg_word_in <= 8'hFB;
        srst <= 1'b1;
        repeat (2) @(posedge sys_clk);
        srst <= 1'b0;
        wr(`IDX_OPTION_CONTROL, 8'h40);
        r0 = rst_cnt;
        repeat (100) @(posedge sys_clk);
        `CHK(rst_cnt == r0, 1'b1)
        close_out();
    end
endmodule

// ===== sim/wdt_sleep_chk.sv
// Purpose: port assertions for watchdog_sleep_wake_control
// Assumes: bound into every instance of the block
// Notes:   bus answer timing plus sleep, wake and vector timing
`timescale 1ns/10ps
module wdt_sleep_chk
    import wdt_sleep_pkg::*;
(
    input wire logic                      sys_clk,
    input wire logic                      srst,
    input wire logic                      read,
    input wire logic                      write,
    input wire logic                      waitrequest,
    input wire logic                      sleep_instr,
    input wire logic                      sleeping,
    input wire logic                      osc_drive_en,
    input wire logic                      wake_pulse,
    input wire logic                      sleep_as_nop,
    input wire logic                      vector_req,
    input wire logic                      chip_reset,
    input wire logic                      master_reset_pin_n,
    input wire wdt_sleep_pkg::prog_addr_t pc_in,
    input wire wdt_sleep_pkg::prog_addr_t fetch_addr,
    input wire wdt_sleep_pkg::prog_addr_t vector_addr
);
    // ==========================================================
    // Assertions
    default clocking @(posedge sys_clk); endclocking
    default disable iff (srst);

    bus_answer_a: assert property ((read || write) && waitrequest |=> !waitrequest)
        else $error("bus answer late");
    bus_stand_a: assert property (!waitrequest |=> waitrequest)
        else $error("bus answer held too long");
    sleep_cause_a: assert property ($rose(sleeping) |-> $past(sleep_instr))
        else $error("sleep without instruction");
    osc_off_a: assert property (osc_drive_en == !sleeping)
        else $error("oscillator drive wrong");
    prefetch_pc_a: assert property (sleep_instr && !sleeping |=> fetch_addr == prog_addr_t'($past(pc_in) + 1))
        else $error("prefetch address wrong");
    wake_pulse_a: assert property ($fell(sleeping) && $past(master_reset_pin_n) |-> wake_pulse)
        else $error("no wake pulse");
    sleep_no_reset_a: assert property (sleeping && $past(sleeping) |-> !chip_reset)
        else $error("reset while asleep");
    nop_sleep_a: assert property (sleep_as_nop |-> !sleeping && $past(sleep_instr))
        else $error("refused sleep entered");
    vector_fixed_a: assert property (vector_req |-> vector_addr == 13'h0004 && !$past(vector_req))
        else $error("vector wrong");
    pin_reset_a: assert property (!master_reset_pin_n |=> chip_reset && !sleeping)
        else $error("pin reset missed");
endmodule

bind watchdog_sleep_wake_control wdt_sleep_chk u_chk (
    .sys_clk(sys_clk), .srst(srst), .read(read), .write(write), .waitrequest(waitrequest),
    .sleep_instr(sleep_instr), .sleeping(sleeping), .osc_drive_en(osc_drive_en), .wake_pulse(wake_pulse),
    .sleep_as_nop(sleep_as_nop), .vector_req(vector_req), .chip_reset(chip_reset),
    .master_reset_pin_n(master_reset_pin_n), .pc_in(pc_in), .fetch_addr(fetch_addr), .vector_addr(vector_addr));
